/* hdl/rsi_pkg.sv */
// Purpose: Shared constants for the reset, stop and interrupt sequencer.
// Assumes: One clock, pclk at 40 MHz.
// Notes: Times are held in their own unit, cycle counts derive from them.
package rsi_pkg;
    localparam int CLK_MHZ = 40;
    localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;
    // Reset release wait, in clock periods.
    localparam int RESET_RELEASE_TC = 2;
    // Handler start delay: 10 periods plus a 5 ns offset, rounded up.
    localparam int IRQ_LAT_TC = 10;
    localparam int IRQ_LAT_OFFSET_PS = 5000;
    localparam int IRQ_LAT_CYCLES = IRQ_LAT_TC +
        (IRQ_LAT_OFFSET_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Stop exit waits.
    localparam int STOP_LONG_CYCLES = 131072;
    localparam int STOP_SHORT_CYCLES = 25;
    // Loop lock time, 0.5 ms, in microseconds.
    localparam int LOOP_LOCK_US = 500;
    localparam int LOOP_LOCK_CYCLES = LOOP_LOCK_US * CLK_MHZ;
    localparam int CNT_W = 20;
    // Register map.
    localparam logic [7:0] ADDR_OPERATING_MODE = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_LOOP_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam int STOP_DELAY_BIT = 6;
    localparam int LOOP_KEEP_BIT = 12;
    localparam int LOOP_EN_BIT = 13;
    localparam int CTRL_STOP_BIT = 0;
    localparam logic [31:0] OPERATING_MODE_RESET = 32'h00000000;
    localparam logic [31:0] CLOCK_LOOP_CTRL_RESET = 32'h00000000;
    localparam int NUM_IRQ = 4;
endpackage

/* hdl/irq_edge_sync.sv */
// Purpose: Synchronises one external request and flags new edges.
// Assumes: The request is asynchronous to pclk and active low.
// Notes: Falling edge detection compares two settled samples.
`timescale 1ns/1ps
module irq_edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req_n,
    output logic level,
    output logic edge_seen
);
    logic meta;
    logic sync;
    logic prev;
    logic next_meta;
    logic next_sync;
    logic next_prev;

    always_comb begin
        next_meta = req_n;
        next_sync = meta;
        next_prev = sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b1;
            sync <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
        end
    end

    // A new request is a fall seen against the previous sampled level.
    assign level = ~sync;
    assign edge_seen = prev & ~sync;
endmodule

/* hdl/reset_stop_irq_sequencer.sv */
// Purpose: Sequences reset release, stop recovery and interrupt intake.
// Assumes: APB slave on pclk; requests and reset are asynchronous pins.
// Notes: No wait-state; every access completes in its access cycle.
//
// How it works
// - Core leaves reset no sooner than two periods after release.
// - Handler starts no sooner than ten periods plus offset after trigger.
// - First handler output is valid within that same latency.
// - Long stop exit waits about 128K periods; level request holds.
// - Short stop exit waits 25 periods; level request holds that long.
// - Stopped loop adds lock time to the selected stop exit wait.
// - Loop shuts down in stop when enabled, unless keep-alive bit is set.
// - Loop disabled means no lock wait, only the stop delay bit.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module reset_stop_irq_sequencer #(
    parameter int STOP_LONG = rsi_pkg::STOP_LONG_CYCLES,
    parameter int LOOP_LOCK = rsi_pkg::LOOP_LOCK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sys_reset_n,
    input wire logic [rsi_pkg::NUM_IRQ-1:0] ext_irq_n,
    output logic core_run,
    output logic loop_power,
    output logic vector_fetch,
    output logic [1:0] vector_id,
    output logic gp_out
);
    typedef enum {ST_RESET, ST_RELEASE, ST_RUN, ST_STOP, ST_LOCK,
                  ST_EXIT, ST_LATENCY} state_t;

    logic [31:0] operating_mode_reg;
    logic [31:0] clock_loop_ctrl_reg;
    logic [31:0] next_omr;
    logic [31:0] next_clock_loop_ctrl_reg;
    logic stop_req;
    logic next_stop_req;
    logic [31:0] next_prdata;
    logic next_pslverr;
    state_t state;
    state_t next_state;
    logic [rsi_pkg::CNT_W-1:0] cnt;
    logic [rsi_pkg::CNT_W-1:0] next_cnt;
    logic [1:0] vec;
    logic [1:0] next_vec;
    logic next_core_run;
    logic next_loop_power;
    logic next_vector_fetch;
    logic next_gp_out;
    logic rst_meta;
    logic rst_sync;
    logic [rsi_pkg::NUM_IRQ-1:0] irq_lvl;
    logic [rsi_pkg::NUM_IRQ-1:0] irq_edge;
    logic [rsi_pkg::NUM_IRQ-1:0] irq_hit;
    logic any_irq;
    logic [1:0] first_irq;
    logic stop_delay;
    logic loop_en;
    logic loop_keep;
    logic [rsi_pkg::CNT_W-1:0] exit_wait;

    ////////////////////////////////////////////////////////////////////
    // Request intake; bit 0 is level-sensitive, the rest edge-triggered.

    genvar gi;
    generate
        for (gi = 0; gi < rsi_pkg::NUM_IRQ; gi++) begin : g_irq
            irq_edge_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .req_n(ext_irq_n[gi]),
                .level(irq_lvl[gi]),
                .edge_seen(irq_edge[gi])
            );
            if (gi == 0) begin : g_lvl
                assign irq_hit[gi] = irq_lvl[gi];
            end else begin : g_edg
                assign irq_hit[gi] = irq_edge[gi];
            end
        end
    endgenerate

    assign any_irq = |irq_hit;

    always_comb begin
        first_irq = 2'h0;
        for (int i = rsi_pkg::NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_hit[i]) begin
                first_irq = 2'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Board reset pin is brought into pclk before the release count.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= sys_reset_n;
            rst_sync <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB registers; zero wait states so pready is high from the first clock after reset.

    always_comb begin
        next_omr = operating_mode_reg;
        next_clock_loop_ctrl_reg = clock_loop_ctrl_reg;
        next_stop_req = stop_req;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (state == ST_STOP || state == ST_LOCK || state == ST_EXIT) begin
            next_stop_req = 1'b0;
        end
        if (psel && !penable) begin
            next_prdata = 32'h00000000;
            case (paddr)
                rsi_pkg::ADDR_OPERATING_MODE:
                    next_prdata = operating_mode_reg;
                rsi_pkg::ADDR_CLOCK_LOOP_CTRL:
                    next_prdata = clock_loop_ctrl_reg;
                rsi_pkg::ADDR_CONTROL:
                    next_prdata = {31'h0, stop_req};
                rsi_pkg::ADDR_STATUS:
                    next_prdata = {16'h0, 4'(irq_lvl), 6'h0,
                                   vec, core_run, loop_power,
                                   1'b0, 1'b0};
                default:
                    next_pslverr = 1'b1;
            endcase
        end
        if (psel && penable) begin
            next_pslverr = pslverr;
            if (pwrite) begin
                case (paddr)
                    rsi_pkg::ADDR_OPERATING_MODE: next_omr = pwdata;
                    rsi_pkg::ADDR_CLOCK_LOOP_CTRL: next_clock_loop_ctrl_reg = pwdata;
                    rsi_pkg::ADDR_CONTROL:
                        next_stop_req = pwdata[rsi_pkg::CTRL_STOP_BIT];
                    default: next_stop_req = stop_req;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operating_mode_reg <= rsi_pkg::OPERATING_MODE_RESET;
            clock_loop_ctrl_reg <= rsi_pkg::CLOCK_LOOP_CTRL_RESET;
            stop_req <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            operating_mode_reg <= next_omr;
            clock_loop_ctrl_reg <= next_clock_loop_ctrl_reg;
            stop_req <= next_stop_req;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            pready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer. The long count is a parameter so benches can shrink it.

    assign stop_delay = operating_mode_reg[rsi_pkg::STOP_DELAY_BIT];
    assign loop_en = clock_loop_ctrl_reg[rsi_pkg::LOOP_EN_BIT];
    assign loop_keep = clock_loop_ctrl_reg[rsi_pkg::LOOP_KEEP_BIT];
    assign exit_wait = stop_delay
        ? rsi_pkg::CNT_W'(rsi_pkg::STOP_SHORT_CYCLES)
        : rsi_pkg::CNT_W'(STOP_LONG);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_vec = vec;
        next_core_run = core_run;
        next_loop_power = loop_power;
        next_vector_fetch = 1'b0;
        next_gp_out = gp_out;
        case (state)
            ST_RESET: begin
                next_core_run = 1'b0;
                next_loop_power = 1'b1;
                next_cnt = '0;
                if (rst_sync) begin
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                next_cnt = cnt + 1'b1;
                if (!rst_sync) begin
                    next_state = ST_RESET;
                end else if (cnt ==
                    rsi_pkg::CNT_W'(rsi_pkg::RESET_RELEASE_TC - 1)) begin
                    next_state = ST_RUN;
                    next_core_run = 1'b1;
                end
            end
            ST_RUN: begin
                if (stop_req) begin
                    next_state = ST_STOP;
                    next_core_run = 1'b0;
                    // An enabled loop idles in stop unless it is kept alive.
                    next_loop_power = !loop_en || loop_keep;
                end else if (any_irq) begin
                    next_state = ST_LATENCY;
                    next_vec = first_irq;
                    next_cnt = '0;
                end
            end
            ST_STOP: begin
                next_cnt = '0;
                if (any_irq) begin
                    next_vec = first_irq;
                    if (loop_en && !loop_keep) begin
                        next_state = ST_LOCK;
                        next_loop_power = 1'b1;
                    end else begin
                        next_state = ST_EXIT;
                    end
                end
            end
            ST_LOCK: begin
                next_cnt = cnt + 1'b1;
                if (cnt == rsi_pkg::CNT_W'(LOOP_LOCK - 1)) begin
                    next_state = ST_EXIT;
                    next_cnt = '0;
                end
            end
            ST_EXIT: begin
                next_cnt = cnt + 1'b1;
                if (cnt == exit_wait - 1'b1) begin
                    // Level request dropped early is simply not served.
                    if (vec != 2'h0 || irq_lvl[0]) begin
                        next_state = ST_LATENCY;
                    end else begin
                        next_state = ST_RUN;
                    end
                    next_core_run = 1'b1;
                    next_cnt = '0;
                end
            end
            ST_LATENCY: begin
                next_cnt = cnt + 1'b1;
                if (cnt ==
                    rsi_pkg::CNT_W'(rsi_pkg::IRQ_LAT_CYCLES - 1)) begin
                    next_state = ST_RUN;
                    next_vector_fetch = 1'b1;
                    next_gp_out = ~gp_out;
                end
            end
            default: next_state = ST_RESET;
        endcase
        // A board reset in any state stops the core, not only while waking.
        if (!rst_sync) begin
            next_state = ST_RESET;
            next_core_run = 1'b0;
            next_vector_fetch = 1'b0;
            next_gp_out = gp_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RESET;
            cnt <= '0;
            vec <= 2'h0;
            core_run <= 1'b0;
            loop_power <= 1'b1;
            vector_fetch <= 1'b0;
            gp_out <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            vec <= next_vec;
            core_run <= next_core_run;
            loop_power <= next_loop_power;
            vector_fetch <= next_vector_fetch;
            gp_out <= next_gp_out;
        end
    end

    assign vector_id = vec;
endmodule

/* tb/rsi_checker_asserts.sv */
// Purpose: Port timing checks for the sequencer.
// Assumes: One clock domain, reset presetn.
// Notes: Counters stand in for long waits.
`timescale 1ns/1ps
module rsi_checker #(
    parameter int STOP_LONG = 40,
    parameter int LOOP_LOCK = 30
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sys_reset_n,
    input wire logic [rsi_pkg::NUM_IRQ-1:0] ext_irq_n,
    input wire logic core_run,
    input wire logic loop_power,
    input wire logic vector_fetch,
    input wire logic [1:0] vector_id,
    input wire logic gp_out
);
    logic [3:0] irq_q;
    logic [20:0] quiet, next_quiet, lock, next_lock;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Saturate so that long idle spells never wrap to a small count.
    always_comb begin
        next_quiet = quiet[20] ? quiet : quiet + 21'h1;
        if (|(irq_q & ~ext_irq_n)) next_quiet = 21'h0;
        next_lock = lock[20] ? lock : lock + 21'h1;
        if (!loop_power) next_lock = 21'h0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 4'hf;
            quiet <= 21'h0;
            lock <= 21'h100000;
        end else begin
            irq_q <= ext_irq_n;
            quiet <= next_quiet;
            lock <= next_lock;
        end
    end
    sequence pulse_s;
        vector_fetch ##1 !vector_fetch;
    endsequence
    handler_late_a: assert property (vector_fetch |->
        quiet >= rsi_pkg::IRQ_LAT_CYCLES) else $error("handler too early");
    handler_due_a: assert property ($fell(ext_irq_n[1]) && core_run &&
        quiet > 40 |-> ##[10:16] vector_fetch) else $error("handler late");
    fetch_pulse_a: assert property ($rose(vector_fetch) |-> pulse_s)
        else $error("fetch pulse not one cycle");
    gp_toggle_a: assert property ($rose(vector_fetch) |-> $changed(gp_out))
        else $error("output did not toggle");
    reset_wait_a: assert property ($rose(core_run) |->
        $past(sys_reset_n, 2) && $past(sys_reset_n, 3))
        else $error("core left reset too soon");
    reset_stop_a: assert property ($fell(sys_reset_n) |-> ##[1:5] !core_run)
        else $error("core kept running in reset");
    relock_wait_a: assert property (vector_fetch |->
        lock >= LOOP_LOCK + 25) else $error("served before relock");
    // The level is judged two sync edges before the 11-cycle latency starts.
    level_held_a: assert property (vector_fetch && vector_id == 2'h0 |->
        $past(ext_irq_n[0], 14) == 1'b0) else $error("dropped level served");
endmodule
bind reset_stop_irq_sequencer rsi_checker #(.STOP_LONG(STOP_LONG),
    .LOOP_LOCK(LOOP_LOCK)) chk (.pclk(pclk), .presetn(presetn),
    .sys_reset_n(sys_reset_n), .ext_irq_n(ext_irq_n), .core_run(core_run),
    .loop_power(loop_power), .vector_fetch(vector_fetch),
    .vector_id(vector_id), .gp_out(gp_out));

/* tb/irq_source.sv */
// Purpose: Board reset source and external request drivers.
// Assumes: Requests active low; bit 0 level, others edge.
// Notes: Each change waits out the least widths, so pacing is kept.
`timescale 1ns/1ps
module irq_source (
    input wire logic pclk,
    output logic sys_reset_n,
    output logic [rsi_pkg::NUM_IRQ-1:0] ext_irq_n
);
    int cyc;
    int stamp [rsi_pkg::NUM_IRQ];
    initial begin
        cyc = 0;
        sys_reset_n = 1'b0;
        ext_irq_n = 4'hf;
        foreach (stamp[i]) stamp[i] = -100;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic board_reset(input int cycles);
        sys_reset_n <= 1'b0;
        repeat ((cycles < 2) ? 2 : cycles) @(posedge pclk);
        sys_reset_n <= 1'b1;
    endtask
    // Six periods a phase paces level lines, four paces edge lines.
    task automatic drive(input int i, input logic v);
        while (cyc - stamp[i] < ((i == 0) ? 6 : 4))
            @(posedge pclk);
        ext_irq_n[i] <= v;
        stamp[i] = cyc;
    endtask
endmodule

/* tb/tb_reset_stop_irq_sequencer.sv */
// Purpose: Self-checking bench for the sequencer.
// Assumes: Shortened stop and lock counts.
// Notes: Latency windows allow for the input synchroniser.
`timescale 1ns/1ps
module tb_reset_stop_irq_sequencer;
    localparam int SL = 40;
    localparam int LL = 30;
    localparam int LAT = rsi_pkg::IRQ_LAT_CYCLES;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gp_out;
    logic core_run, loop_power, vector_fetch, sys_reset_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] ext_irq_n;
    logic [1:0] vector_id;
    logic [2:0] cases [6] = '{3'h3, 3'h7, 3'h6, 3'h2, 3'h0, 3'h4};
    int miscompares, checked;
    irq_source src (.pclk(pclk), .sys_reset_n(sys_reset_n),
        .ext_irq_n(ext_irq_n));
    reset_stop_irq_sequencer #(.STOP_LONG(SL), .LOOP_LOCK(LL)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sys_reset_n(sys_reset_n),
        .ext_irq_n(ext_irq_n), .core_run(core_run), .loop_power(loop_power),
        .vector_fetch(vector_fetch), .vector_id(vector_id), .gp_out(gp_out));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic in_range(input int n, input int lo, input int hi);
        chk((n >= lo && n <= hi) ? 32'h1 : 32'(n), 32'h1);
        if (n >= 2000) summarize();
    endtask
    // Called just after a rising edge; ends just after one.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] exp, input logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) in_range(2000, 0, 0);
        if (!wr) chk(prdata, exp);
        chk({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic serve(input int i, input int wt);
        int n;
        logic g;
        g = gp_out;
        src.drive(i, 1'b0);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (vector_fetch !== 1'b1 && n < 2000);
        in_range(n, wt + LAT + 2, wt + LAT + 8);
        @(posedge pclk);
        chk({30'h0, vector_id}, 32'(i));
        chk({31'h0, gp_out}, {31'h0, ~g});
        n = 0;
        if (i > 0) repeat (20) begin
            @(negedge pclk);
            n += vector_fetch;
        end
        chk(32'(n), 32'h0);
        @(posedge pclk);
        src.drive(i, 1'b1);
        repeat (20) @(posedge pclk);
    endtask
    task automatic stop_exit(input logic dly, input logic en, input logic k);
        logic [31:0] d;
        d = 32'h0;
        d[rsi_pkg::STOP_DELAY_BIT] = dly;
        apb(1'b1, rsi_pkg::ADDR_OPERATING_MODE, d, 32'h0, 1'b0);
        apb(1'b0, rsi_pkg::ADDR_OPERATING_MODE, 32'h0, d, 1'b0);
        d = 32'h0;
        d[rsi_pkg::LOOP_EN_BIT] = en;
        d[rsi_pkg::LOOP_KEEP_BIT] = k;
        apb(1'b1, rsi_pkg::ADDR_CLOCK_LOOP_CTRL, d, 32'h0, 1'b0);
        apb(1'b1, rsi_pkg::ADDR_CONTROL, 32'h1, 32'h0, 1'b0);
        repeat (3) @(posedge pclk);
        chk({31'h0, core_run}, 32'h0);
        chk({31'h0, loop_power}, {31'h0, !(en && !k)});
        serve(0, (dly ? 25 : SL) + ((en && !k) ? LL : 0));
        chk({31'h0, loop_power}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        miscompares = 0;
        checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            src.board_reset(2 + 3 * k);
            chk({31'h0, core_run}, 32'h0);
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (core_run !== 1'b1 && n < 2000);
            in_range(n, 3, 8);
            @(posedge pclk);
        end
        apb(1'b0, rsi_pkg::ADDR_OPERATING_MODE, 32'h0,
            rsi_pkg::OPERATING_MODE_RESET, 1'b0);
        apb(1'b0, rsi_pkg::ADDR_CLOCK_LOOP_CTRL, 32'h0,
            rsi_pkg::CLOCK_LOOP_CTRL_RESET, 1'b0);
        apb(1'b0, rsi_pkg::ADDR_STATUS, 32'h0, 32'h0000000c, 1'b0);
        apb(1'b0, rsi_pkg::ADDR_CONTROL, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 8'h40, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        for (int i = 1; i < 4; i++) serve(i, 0);
        serve(0, 0);
        for (int c = 0; c < 6; c++)
            stop_exit(cases[c][2], cases[c][1], cases[c][0]);
        summarize();
    end
endmodule
